// ---- fwsp_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef FWSP_DEFINES_SVH
`define FWSP_DEFINES_SVH

// Register bus geometry
`define FWSP_ADDR_W        20
`define FWSP_DATA_W        8

// Register byte addresses
`define FWSP_ADDR_CTRLH    20'h4_4f08
`define FWSP_ADDR_ENABLE   20'h4_4f0b
`define FWSP_ADDR_STATUS   20'h4_4f0c
`define FWSP_ADDR_MODE2    20'h4_4f0d
`define FWSP_ADDR_TXHOLD   20'h4_4f0e
`define FWSP_ADDR_RXHOLD   20'h4_4f0f

// Control high register fields
`define FWSP_CTRLH_MASTER  5
`define FWSP_CTRLH_RX_STOP 6

// Mode register 2: chip select configuration field
`define FWSP_MODE2_CSS_HI  5
`define FWSP_MODE2_CSS_LO  4
`define FWSP_CSS_OUTPUT    2'b10
`define FWSP_CSS_INPUT     2'b01

// Status register fields
`define FWSP_ST_TX_EMPTY   7
`define FWSP_ST_TX_CMPL    6
`define FWSP_ST_RX_FULL    5
`define FWSP_ST_CE         4
`define FWSP_ST_OVERRUN    2

// Reset values
`define FWSP_ENABLE_RST    8'h00
`define FWSP_BYTE_RST      8'h00
`define FWSP_IDLE_FILL     8'hff

// Frame and serial clock timing
`define FWSP_FRAME_LAST    3'h7
`define FWSP_CLK_NS        25
`define FWSP_SCK_HALF_NS   100
`define FWSP_SCK_HALF_CYC  ((`FWSP_SCK_HALF_NS + `FWSP_CLK_NS - 1) / `FWSP_CLK_NS)

`endif

// ---- fwsp_pkg.sv ----
// Types shared by the four-wire serial port
`default_nettype none
package fwsp_pkg;

	// Transfer sequencer states
	typedef enum logic [1:0] {
		FWSP_ST_IDLE   = 2'b00,
		FWSP_ST_ARB    = 2'b01,
		FWSP_ST_MSHIFT = 2'b10,
		FWSP_ST_SSHIFT = 2'b11
	} fwsp_state_t;

	// Enable register layout, bit 7 first
	typedef struct packed {
		logic       tx_empty_irq_enable;
		logic       tx_end_irq_enable;
		logic       rx_irq_enable;
		logic       rsvd_hi;
		logic       transmit_enable;
		logic       receive_enable;
		logic [1:0] rsvd_lo;
	} fwsp_enable_t;

endpackage
`default_nettype wire

// ---- fwsp_port.sv ----
// Four-wire serial port channel: register slave, master/slave shifter, arbitration
// Operation
// - Master drives own serial clock, shifts data
// - Slave uses pin clock only while selected
// - Holder write clears empty, loads, starts shifting
// - Empty holder with enable requests interrupt
// - Pending word starts next frame without gap
// - Empty at frame end sets complete flag
// - After completion clock and select go high
// - No transmit while overrun flag set
// - Master data output floats while select high
// - Slave data output floats while select high
// - Master dummy read starts reception clock
// - Full word stored, full flag, interrupt
// - Reading receive holder clears full flag
// - Stop control halts clock after frame
// - Read with receive enabled restarts clock
// - Word over full holder sets overrun, halts
// - No reception while overrun flag set
// - Low select before transmit: conflict, slave
// - No transmit while conflict flag set
// - Select configuration 01b makes pin input
`timescale 1ns/1ps
`default_nettype none
`include "fwsp_defines.svh"

module fwsp_port
	import fwsp_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     srst,
	input  wire logic [`FWSP_ADDR_W-1:0]  reg_addr,
	input  wire logic [`FWSP_DATA_W-1:0]  reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [`FWSP_DATA_W-1:0]  reg_rdata,
	input  wire logic                     serial_clock_pin_in,
	output logic                          serial_clock_pin_out,
	output logic                          serial_clock_pin_oe,
	input  wire logic                     chip_select_pin_n_in,
	output logic                          chip_select_pin_n_out,
	output logic                          chip_select_pin_n_oe,
	output logic                          data_out_pin_out,
	output logic                          data_out_pin_oe,
	input  wire logic                     data_in_pin_in,
	output logic                          tx_empty_irq,
	output logic                          tx_end_irq,
	output logic                          rx_full_irq
);

	// Software-only configuration
	fwsp_enable_t        enable_reg;       // Enable register
	logic [1:0]          select_cfg_reg;   // Chip select configuration field
	logic                rx_stop_ctrl_reg; // Stop after current received frame
	// Sequencer state and hardware-touched flags
	fwsp_state_t         state_reg,        state_next;
	logic                master_reg,       master_next;     // Master role
	logic [7:0]          shreg_reg,        shreg_next;      // Shift register
	logic [7:0]          txhold_reg,       txhold_next;     // Transmit holder
	logic [7:0]          rxhold_reg,       rxhold_next;     // Receive holder
	logic                tx_empty_reg,     tx_empty_next;
	logic                tx_cmpl_reg,      tx_cmpl_next;
	logic                rx_full_reg,      rx_full_next;
	logic                overrun_reg,      overrun_next;
	logic                conflict_reg,     conflict_next;
	logic                rx_req_reg,       rx_req_next;     // Pending dummy-read start
	logic [2:0]          bit_cnt_reg,      bit_cnt_next;    // Bit within frame
	logic [2:0]          div_reg,          div_next;        // Half-period divider
	// Pin drivers, all registered
	logic                sck_reg,          sck_next;
	logic                cs_reg,           cs_next;
	logic                dout_reg,         dout_next;
	logic                dout_oe_reg,      dout_oe_next;
	logic [7:0]          rdata_reg;
	logic                txe_irq_reg,      txd_irq_reg,     rxf_irq_reg;
	// Synchronisers: stage 1 feeds stage 2 only; stage 3 keeps clock history
	logic [2:0]          sync1_reg;        // {clock, select, data}
	logic [2:0]          sync2_reg;
	logic                sck_hist_reg;

	// Synchronised pins and edges
	wire                 sck_s    = sync2_reg[2];
	wire                 cs_s     = sync2_reg[1];
	wire                 din_s    = sync2_reg[0];
	wire                 s_rise   = sck_s & ~sck_hist_reg;
	wire                 s_fall   = ~sck_s & sck_hist_reg;

	// Register decode
	wire                 wr_enable = reg_wr && (reg_addr == `FWSP_ADDR_ENABLE);
	wire                 wr_ctrlh  = reg_wr && (reg_addr == `FWSP_ADDR_CTRLH);
	wire                 wr_status = reg_wr && (reg_addr == `FWSP_ADDR_STATUS);
	wire                 wr_mode2  = reg_wr && (reg_addr == `FWSP_ADDR_MODE2);
	wire                 wr_txhold = reg_wr && (reg_addr == `FWSP_ADDR_TXHOLD);
	wire                 rd_rxhold = reg_rd && (reg_addr == `FWSP_ADDR_RXHOLD);

	// Mode qualifiers
	wire                 tx_on     = enable_reg.transmit_enable;
	wire                 rx_on     = enable_reg.receive_enable;
	wire                 cfg_out   = (select_cfg_reg == `FWSP_CSS_OUTPUT);
	wire                 cfg_in    = (select_cfg_reg == `FWSP_CSS_INPUT);
	wire                 half_done = (div_reg == 3'(`FWSP_SCK_HALF_CYC - 1));
	wire                 last_bit  = (bit_cnt_reg == `FWSP_FRAME_LAST);
	// Transmission may load a word only with no error flag pending
	wire                 tx_ready  = tx_on && !tx_empty_reg && !overrun_reg && !conflict_reg;

	// Frame end: master at the close of the last high half, slave at last rising edge
	wire                 m_frame_end = (state_reg == FWSP_ST_MSHIFT) && half_done
	                                   && sck_reg && last_bit;
	wire                 s_frame_end = (state_reg == FWSP_ST_SSHIFT) && !cs_s
	                                   && s_rise && last_bit;
	wire                 frame_end   = m_frame_end | s_frame_end;
	// The slave still holds its final bit on the data pin
	wire [7:0]           rx_word     = s_frame_end ? {shreg_reg[6:0], din_s} : shreg_reg;
	wire                 ovr_hit     = rx_on && rx_full_reg;

	// Status register image
	logic [7:0]          status_val;
	always_comb begin
		status_val                  = `FWSP_BYTE_RST;
		status_val[`FWSP_ST_TX_EMPTY] = tx_empty_reg;
		status_val[`FWSP_ST_TX_CMPL]  = tx_cmpl_reg;
		status_val[`FWSP_ST_RX_FULL]  = rx_full_reg;
		status_val[`FWSP_ST_CE]       = conflict_reg;
		status_val[`FWSP_ST_OVERRUN]  = overrun_reg;
	end

	// Control high and mode 2 images
	logic [7:0]          ctrlh_val;
	logic [7:0]          mode2_val;
	always_comb begin
		ctrlh_val                        = `FWSP_BYTE_RST;
		ctrlh_val[`FWSP_CTRLH_MASTER]    = master_reg;
		ctrlh_val[`FWSP_CTRLH_RX_STOP]   = rx_stop_ctrl_reg;
		mode2_val                        = `FWSP_BYTE_RST;
		mode2_val[`FWSP_MODE2_CSS_HI]    = select_cfg_reg[1];
		mode2_val[`FWSP_MODE2_CSS_LO]    = select_cfg_reg[0];
	end

	// Read selection; unmapped addresses return zero
	wire [7:0]           rdata_sel =
		(reg_addr == `FWSP_ADDR_ENABLE) ? enable_reg :
		(reg_addr == `FWSP_ADDR_CTRLH)  ? ctrlh_val  :
		(reg_addr == `FWSP_ADDR_STATUS) ? status_val :
		(reg_addr == `FWSP_ADDR_MODE2)  ? mode2_val  :
		(reg_addr == `FWSP_ADDR_TXHOLD) ? txhold_reg :
		(reg_addr == `FWSP_ADDR_RXHOLD) ? rxhold_reg : `FWSP_BYTE_RST;

	// Sequencer and flag next-state; software clears first so hardware sets win, except the empty flag clear, which comes last
	always_comb begin
		state_next    = state_reg;
		master_next   = master_reg;
		shreg_next    = shreg_reg;
		txhold_next   = txhold_reg;
		rxhold_next   = rxhold_reg;
		tx_empty_next = tx_empty_reg;
		tx_cmpl_next  = tx_cmpl_reg;
		rx_full_next  = rx_full_reg;
		overrun_next  = overrun_reg;
		conflict_next = conflict_reg;
		rx_req_next   = rx_req_reg;
		bit_cnt_next  = bit_cnt_reg;
		div_next      = div_reg;
		sck_next      = sck_reg;
		cs_next       = cs_reg;
		dout_next     = dout_reg;
		// Software side effects
		if (wr_ctrlh)
			master_next = reg_wdata[`FWSP_CTRLH_MASTER];
		if (wr_status) begin
			// Write zero to clear a flag, writing one leaves it
			tx_cmpl_next  = tx_cmpl_reg & reg_wdata[`FWSP_ST_TX_CMPL];
			overrun_next  = overrun_reg & reg_wdata[`FWSP_ST_OVERRUN];
			conflict_next = conflict_reg & reg_wdata[`FWSP_ST_CE];
		end
		if (wr_txhold) begin
			txhold_next = reg_wdata;
			if (tx_on)
				tx_cmpl_next = 1'b0;
		end
		if (rd_rxhold) begin
			rx_full_next = 1'b0;
			// Restart only once the clock has stopped
			if (rx_on && master_reg && state_reg == FWSP_ST_IDLE)
				rx_req_next = 1'b1;
		end
		unique case (state_reg)
			FWSP_ST_IDLE: begin
				sck_next = 1'b1;
				cs_next  = 1'b1;
				if (master_reg) begin
					if (tx_ready) begin
						state_next = FWSP_ST_ARB;
					end else if (rx_on && !tx_on && rx_req_reg && !overrun_reg) begin
						// Receive-only frame; idle-high fill on the data pin
						rx_req_next  = 1'b0;
						shreg_next   = `FWSP_IDLE_FILL;
						dout_next    = 1'b1;
						cs_next      = 1'b0;
						sck_next     = 1'b0;
						div_next     = '0;
						bit_cnt_next = '0;
						state_next   = FWSP_ST_MSHIFT;
					end
				end else if (cfg_in && !cs_s && (tx_on || rx_on) && !overrun_reg) begin
					// Selected by the far master
					bit_cnt_next = '0;
					state_next   = FWSP_ST_SSHIFT;
					if (tx_ready) begin
						shreg_next    = txhold_reg;
						dout_next     = txhold_reg[7];
						tx_empty_next = 1'b1;
					end else begin
						shreg_next    = `FWSP_IDLE_FILL;
						dout_next     = 1'b1;
					end
				end
			end
			FWSP_ST_ARB: begin
				if (cfg_out && !cs_s) begin
					// Another master holds select low: give up the bus
					conflict_next = 1'b1;
					master_next   = 1'b0;
					state_next    = FWSP_ST_IDLE;
				end else begin
					shreg_next    = txhold_reg;
					dout_next     = txhold_reg[7];
					tx_empty_next = 1'b1;
					cs_next       = 1'b0;
					sck_next      = 1'b0;
					div_next      = '0;
					bit_cnt_next  = '0;
					state_next    = FWSP_ST_MSHIFT;
				end
			end
			FWSP_ST_MSHIFT: begin
				if (!half_done) begin
					div_next = div_reg + 3'h1;
				end else begin
					div_next = '0;
					if (!sck_reg) begin
						// Rising edge: sample the far side
						sck_next   = 1'b1;
						shreg_next = {shreg_reg[6:0], din_s};
					end else if (!last_bit) begin
						// Falling edge: launch next bit
						sck_next     = 1'b0;
						dout_next    = shreg_reg[7];
						bit_cnt_next = bit_cnt_reg + 3'h1;
					end
				end
			end
			FWSP_ST_SSHIFT: begin
				if (cs_s) begin
					// Deselected mid-frame: drop the partial word
					state_next   = FWSP_ST_IDLE;
					bit_cnt_next = '0;
				end else if (s_fall) begin
					dout_next = shreg_reg[7];
				end else if (s_rise) begin
					shreg_next   = {shreg_reg[6:0], din_s};
					bit_cnt_next = bit_cnt_reg + 3'h1;
				end
			end
		endcase
		// Frame completion shared by both roles
		if (frame_end) begin
			bit_cnt_next = '0;
			if (rx_on && !rx_full_reg) begin
				rxhold_next  = rx_word;
				rx_full_next = 1'b1;
			end
			if (ovr_hit)
				overrun_next = 1'b1;
			if (ovr_hit || overrun_reg) begin
				state_next = FWSP_ST_IDLE;
				sck_next   = 1'b1;
				cs_next    = 1'b1;
			end else if (tx_ready) begin
				// Back-to-back word, no idle half period
				shreg_next    = txhold_reg;
				dout_next     = txhold_reg[7];
				tx_empty_next = 1'b1;
				sck_next      = m_frame_end ? 1'b0 : sck_reg;
			end else if (tx_on && s_frame_end) begin
				tx_cmpl_next = 1'b1;
				shreg_next   = `FWSP_IDLE_FILL;
				dout_next    = 1'b1;
			end else if (tx_on || rx_stop_ctrl_reg || !rx_on || s_frame_end) begin
				// Master stops here; slave keeps filling while selected
				tx_cmpl_next = tx_on ? 1'b1 : tx_cmpl_reg;
				state_next   = s_frame_end ? state_reg : FWSP_ST_IDLE;
				sck_next     = 1'b1;
				cs_next      = 1'b1;
				shreg_next   = `FWSP_IDLE_FILL;
			end else begin
				// Continuous master reception
				shreg_next = `FWSP_IDLE_FILL;
				dout_next  = 1'b1;
				sck_next   = 1'b0;
			end
		end
		// New word beats the load of the old one for the empty flag
		if (wr_txhold && tx_on)
			tx_empty_next = 1'b0;
	end

	// Data output enable follows the select level it will stand beside
	always_comb begin
		if (master_reg)
			dout_oe_next = !cs_next;
		else
			dout_oe_next = tx_on && !cs_s;
	end

	// Pin synchronisers, clock history for edge detection
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_reg    <= 3'b110;
			sync2_reg    <= 3'b110;
			sck_hist_reg <= 1'b1;
		end else begin
			sync1_reg    <= {serial_clock_pin_in, chip_select_pin_n_in, data_in_pin_in};
			sync2_reg    <= sync1_reg;
			sck_hist_reg <= sync2_reg[2];
		end
	end

	// Software-only configuration registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			enable_reg       <= `FWSP_ENABLE_RST;
			select_cfg_reg   <= 2'b00;
			rx_stop_ctrl_reg <= 1'b0;
		end else begin
			if (wr_enable)
				enable_reg <= reg_wdata & 8'hec;
			if (wr_mode2)
				select_cfg_reg <= {reg_wdata[`FWSP_MODE2_CSS_HI], reg_wdata[`FWSP_MODE2_CSS_LO]};
			if (wr_ctrlh)
				rx_stop_ctrl_reg <= reg_wdata[`FWSP_CTRLH_RX_STOP];
		end
	end

	// Sequencer and flag state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg    <= FWSP_ST_IDLE;
			master_reg   <= 1'b0;
			shreg_reg    <= `FWSP_IDLE_FILL;
			txhold_reg   <= `FWSP_BYTE_RST;
			rxhold_reg   <= `FWSP_BYTE_RST;
			tx_empty_reg <= 1'b1;
			tx_cmpl_reg  <= 1'b1;
			rx_full_reg  <= 1'b0;
			overrun_reg  <= 1'b0;
			conflict_reg <= 1'b0;
			rx_req_reg   <= 1'b0;
			bit_cnt_reg  <= '0;
			div_reg      <= '0;
		end else begin
			state_reg    <= state_next;
			master_reg   <= master_next;
			shreg_reg    <= shreg_next;
			txhold_reg   <= txhold_next;
			rxhold_reg   <= rxhold_next;
			tx_empty_reg <= tx_empty_next;
			tx_cmpl_reg  <= tx_cmpl_next;
			rx_full_reg  <= rx_full_next;
			overrun_reg  <= overrun_next;
			conflict_reg <= conflict_next;
			rx_req_reg   <= rx_req_next;
			bit_cnt_reg  <= bit_cnt_next;
			div_reg      <= div_next;
		end
	end

	// Registered pins, read data and interrupt requests
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sck_reg     <= 1'b1;
			cs_reg      <= 1'b1;
			dout_reg    <= 1'b1;
			dout_oe_reg <= 1'b0;
			rdata_reg   <= `FWSP_BYTE_RST;
			txe_irq_reg <= 1'b0;
			txd_irq_reg <= 1'b0;
			rxf_irq_reg <= 1'b0;
		end else begin
			sck_reg     <= sck_next;
			cs_reg      <= cs_next;
			dout_reg    <= dout_next;
			dout_oe_reg <= dout_oe_next;
			rdata_reg   <= reg_rd ? rdata_sel : `FWSP_BYTE_RST;
			txe_irq_reg <= enable_reg.tx_empty_irq_enable & tx_empty_reg;
			txd_irq_reg <= enable_reg.tx_end_irq_enable & tx_cmpl_reg;
			rxf_irq_reg <= enable_reg.rx_irq_enable & (rx_full_reg | overrun_reg);
		end
	end

	// Output ports straight from flip-flops, except the select enable, which gates master_reg with the configuration
	assign reg_rdata             = rdata_reg;
	assign serial_clock_pin_out  = sck_reg;
	assign serial_clock_pin_oe   = master_reg;
	assign chip_select_pin_n_out = cs_reg;
	assign chip_select_pin_n_oe  = master_reg & cfg_out;
	assign data_out_pin_out      = dout_reg;
	assign data_out_pin_oe       = dout_oe_reg;
	assign tx_empty_irq          = txe_irq_reg;
	assign tx_end_irq            = txd_irq_reg;
	assign rx_full_irq           = rxf_irq_reg;

	// Checks on the sequencer
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	property p_txi_cause;
		tx_empty_irq |-> $past(enable_reg.tx_empty_irq_enable) && $past(tx_empty_reg);
	endproperty
	a_txi_cause: assert property (p_txi_cause) else $error("tx empty request without cause");

	property p_master_float;
		cs_reg && $past(master_reg) && master_reg |-> !data_out_pin_oe;
	endproperty
	a_master_float: assert property (p_master_float) else $error("master drives data, select high");

	property p_slave_float;
		data_out_pin_oe && !$past(master_reg) |-> !$past(cs_s);
	endproperty
	a_slave_float: assert property (p_slave_float) else $error("slave drives data, deselected");

	property p_read_clears;
		rd_rxhold && !frame_end |=> !rx_full_reg;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("full flag kept after read");

	property p_overrun_idle;
		state_reg == FWSP_ST_IDLE && overrun_reg |=> state_reg == FWSP_ST_IDLE;
	endproperty
	a_overrun_idle: assert property (p_overrun_idle) else $error("transfer began under overrun");

	property p_conflict;
		state_reg == FWSP_ST_ARB && cfg_out && !cs_s |=> conflict_reg && !master_reg
			&& state_reg == FWSP_ST_IDLE;
	endproperty
	a_conflict: assert property (p_conflict) else $error("arbitration loss not flagged");

	property p_done_high;
		$rose(tx_cmpl_reg) && master_reg |-> sck_reg && cs_reg ##1 sck_reg [*2];
	endproperty
	a_done_high: assert property (p_done_high) else $error("pins not high after completion");

	property p_rx_store;
		frame_end && rx_on && !rx_full_reg |=> rx_full_reg && rxhold_reg == $past(rx_word);
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("received word not stored");

	property p_overrun_set;
		frame_end && rx_on && rx_full_reg |=> overrun_reg && state_reg == FWSP_ST_IDLE;
	endproperty
	a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

	property p_rx_stop;
		m_frame_end && !tx_on && rx_stop_ctrl_reg |=> state_reg == FWSP_ST_IDLE && sck_reg;
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("clock kept after stop");

	property p_gapless;
		m_frame_end && tx_ready && !ovr_hit |=> state_reg == FWSP_ST_MSHIFT && !cs_reg
			&& tx_empty_reg;
	endproperty
	a_gapless: assert property (p_gapless) else $error("gap between queued frames");

endmodule
`default_nettype wire

// ---- fwsp_far_dev.sv ----
// Far-side device model: selected slave responder and slow external master
`timescale 1ns/1ps
`default_nettype none
module fwsp_far_dev #(
	parameter logic [7:0] REPLY = 8'h96
) (
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            miso,
	output logic            ext_sck,
	output logic            ext_cs_n,
	output logic [7:0]      last_rx,
	output logic [7:0]      prev_rx
);
	logic [7:0] sh;  // Capture shifter
	int         cnt; // Bits taken in this frame
	logic       mst; // Acting as the external master
	// Idle: clock parked high, select released
	initial begin
		{miso, ext_sck, ext_cs_n, mst} = 4'h6;
		{sh, last_rx, prev_rx} = 24'h00_0000;
		cnt = 0;
	end
	// A released line shows the inverse of its last bit, never a stale level
	always @(cs_n) if (!mst) begin
		cnt = 0;
		miso = (cs_n === 1'b0) ? REPLY[7] : ~miso;
	end
	// MSB first: capture on rise
	always @(posedge sck) if (cs_n === 1'b0 && !mst) begin
		sh = {sh[6:0], mosi};
		cnt = cnt + 1;
		if (cnt == 8) begin
			prev_rx = last_rx;
			last_rx = sh;
			cnt = 0;
		end
	end
	// Next bit on fall
	always @(negedge sck) if (cs_n === 1'b0 && !mst) miso = REPLY[7-cnt];
	// Slow master frame, 200 ns clock only inside the select window
	task automatic send(input logic [7:0] b);
		mst = 1'b1;
		ext_cs_n = 1'b0;
		#207;
		for (int i = 7; i >= 0; i--) begin
			ext_sck = 1'b0;
			miso = b[i];
			#100;
			ext_sck = 1'b1;
			#100;
		end
		#200;
		ext_cs_n = 1'b1;
		miso = ~miso;
		#1 mst = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- fwsp_port_tb_top.sv ----
// Bench of the serial port channel: register table, then link scenarios
`timescale 1ns/1ps
`default_nettype none
`include "fwsp_defines.svh"
module fwsp_port_tb_top
	import fwsp_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [19:0] a;
		logic [7:0]  v;
	} fwsp_row_t;
	// Rows: a write, or a read with the value it must return
	localparam fwsp_row_t ROWS [13] = '{
		'{1'b0, `FWSP_ADDR_ENABLE, 8'h00}, '{1'b0, `FWSP_ADDR_STATUS, 8'hc0},
		'{1'b0, `FWSP_ADDR_CTRLH, 8'h00}, '{1'b0, `FWSP_ADDR_MODE2, 8'h00},
		'{1'b1, 20'h4_4f10, 8'hff}, '{1'b0, 20'h4_4f10, 8'h00},
		'{1'b1, `FWSP_ADDR_CTRLH, 8'h20}, '{1'b1, `FWSP_ADDR_MODE2, 8'h20},
		'{1'b1, `FWSP_ADDR_ENABLE, 8'hff}, '{1'b0, `FWSP_ADDR_ENABLE, 8'hec},
		'{1'b1, `FWSP_ADDR_ENABLE, 8'he8}, '{1'b0, `FWSP_ADDR_CTRLH, 8'h20},
		'{1'b0, `FWSP_ADDR_MODE2, 8'h20}};
	logic        core_clk, srst, reg_wr, reg_rd, conflict_n;
	logic [19:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d, last_rx, prev_rx;
	logic        serial_clock_pin_out, serial_clock_pin_oe, chip_select_pin_n_out;
	logic        chip_select_pin_n_oe, data_out_pin_out, data_out_pin_oe, data_in_pin_in;
	logic        tx_empty_irq, tx_end_irq, rx_full_irq, ext_sck, ext_cs_n;
	// Pin levels: the clock pin is driven by whoever enables it, data lines connect straight through, select has a pull-up
	wire logic   serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : ext_sck;
	wire logic   chip_select_pin_n_in = ext_cs_n & conflict_n &
		(chip_select_pin_n_oe ? chip_select_pin_n_out : 1'b1);
	int          failures, n_checks, cs_rises;
	fwsp_port fwsp_port_inst (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe,
		.chip_select_pin_n_in, .chip_select_pin_n_out, .chip_select_pin_n_oe,
		.data_out_pin_out, .data_out_pin_oe, .data_in_pin_in, .tx_empty_irq, .tx_end_irq,
		.rx_full_irq);
	fwsp_far_dev fwsp_far_dev_inst (.sck(serial_clock_pin_in), .cs_n(chip_select_pin_n_in),
		.mosi(data_out_pin_out), .miso(data_in_pin_in), .ext_sck, .ext_cs_n, .last_rx,
		.prev_rx);
	// 40 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Select releases, to catch a gap between frames
	always @(posedge chip_select_pin_n_out) cs_rises++;
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [19:0] a, input logic [7:0] v);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [19:0] a, output logic [7:0] v);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Poll a status bit under a bound; running out ends the run
	task automatic wait_st(input int n);
		logic [7:0] s;
		for (int i = 0; i < 200; i++) begin
			rd(`FWSP_ADDR_STATUS, s);
			if (s[n] === 1'b1) return;
		end
		failures++;
		$display("[FAIL] %0t: status wait timed out", $time);
		end_of_test();
	endtask
	// The serial clock must stay parked for 100 cycles
	task automatic quiet();
		int lows;
		lows = 0;
		repeat (100) @(posedge core_clk) if (serial_clock_pin_out !== 1'b1) lows++;
		chk(8'(lows), 8'h00);
	endtask
	initial begin
		{srst, reg_wr, reg_rd, conflict_n} = 4'h9;
		{reg_addr, reg_wdata} = 28'h000_0000;
		{failures, n_checks, cs_rises} = 0;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].v);
			else begin
				rd(ROWS[i].a, d);
				chk(d, ROWS[i].v);
			end
		end
		// Two words back to back under one select window
		cs_rises = 0;
		wr(`FWSP_ADDR_TXHOLD, 8'ha5);
		wait_st(7);
		wr(`FWSP_ADDR_TXHOLD, 8'h3c);
		wait_st(6);
		chk(prev_rx, 8'ha5);
		chk(last_rx, 8'h3c);
		chk(8'(cs_rises), 8'h01);
		chk({3'h0, serial_clock_pin_out, chip_select_pin_n_out, data_out_pin_oe, tx_end_irq,
			tx_empty_irq}, 8'h1b);
		// Master reception ended by the stop control
		wr(`FWSP_ADDR_ENABLE, 8'h24);
		rd(`FWSP_ADDR_RXHOLD, d);
		wait_st(5);
		wr(`FWSP_ADDR_CTRLH, 8'h60);
		rd(`FWSP_ADDR_RXHOLD, d);
		chk(d, 8'h96);
		rd(`FWSP_ADDR_STATUS, d);
		chk(d, 8'hc0);
		wait_st(5);
		quiet();
		wr(`FWSP_ADDR_ENABLE, 8'h20);
		wr(`FWSP_ADDR_CTRLH, 8'h20);
		rd(`FWSP_ADDR_RXHOLD, d);
		chk(d, 8'h96);
		// Overrun stops reception and blocks transmission until cleared
		wr(`FWSP_ADDR_ENABLE, 8'h24);
		rd(`FWSP_ADDR_RXHOLD, d);
		wait_st(2);
		chk({7'h00, rx_full_irq}, 8'h01);
		rd(`FWSP_ADDR_RXHOLD, d);
		quiet();
		wr(`FWSP_ADDR_ENABLE, 8'h28);
		wr(`FWSP_ADDR_TXHOLD, 8'h11);
		quiet();
		wr(`FWSP_ADDR_STATUS, 8'h00);
		wait_st(6);
		chk(last_rx, 8'h11);
		// Select pulled low by another master before a frame
		@(posedge core_clk) conflict_n <= 1'b0;
		wr(`FWSP_ADDR_ENABLE, 8'h08);
		wr(`FWSP_ADDR_TXHOLD, 8'h55);
		quiet();
		rd(`FWSP_ADDR_STATUS, d);
		chk(d & 8'h10, 8'h10);
		rd(`FWSP_ADDR_CTRLH, d);
		chk(d, 8'h00);
		// Slave reception from the far master's 200 ns clock
		@(posedge core_clk) conflict_n <= 1'b1;
		wr(`FWSP_ADDR_STATUS, 8'h00);
		wr(`FWSP_ADDR_ENABLE, 8'h00);
		wr(`FWSP_ADDR_MODE2, 8'h10);
		wr(`FWSP_ADDR_ENABLE, 8'h0c);
		fwsp_far_dev_inst.send(8'h5a);
		repeat (10) @(posedge core_clk);
		chk({7'h00, data_out_pin_oe}, 8'h00);
		rd(`FWSP_ADDR_RXHOLD, d);
		chk(d, 8'h5a);
		end_of_test();
	end
endmodule
`default_nettype wire
